/* logic/can_flags_regs.vh */
`ifndef CAN_FLAGS_REGS_VH
`define CAN_FLAGS_REGS_VH

// ==================================================
// register byte offsets
`define OFS_TX_MAILBOX_STATUS 8'h08
`define OFS_RX_QUEUE0_STATUS 8'h0C
`define OFS_RX_QUEUE1_STATUS 8'h10
`define OFS_IRQ_STATUS 8'h20
`define OFS_IRQ_MASK 8'h24
`define OFS_RX_CONFIG 8'h28
`define OFS_TX_REQUEST 8'h2C

// ==================================================
// register select codes
`define SEL_NONE 3'h0
`define SEL_TXST 3'h1
`define SEL_RXQ0 3'h2
`define SEL_RXQ1 3'h3
`define SEL_IRQS 3'h4
`define SEL_IRQM 3'h5
`define SEL_CFG 3'h6
`define SEL_TXREQ 3'h7

// ==================================================
// transmit status fields, mailbox n at base n*8
`define MB_STRIDE 8
`define MB_DONE 0
`define MB_DONE_OK 1
`define MB_ARB_LOST 2
`define MB_TX_FAULT 3
`define MB_ABORT 7

// ==================================================
// receive queue status fields
`define RXQ_COUNT_LSB 0
`define RXQ_COUNT_MSB 1
`define RXQ_FULL 3
`define RXQ_OVERFLOW 4
`define RXQ_RELEASE 5
`define RXQ_OVERRUN 8
`define RXQ_DEPTH 2'h3

// ==================================================
// interrupt status bits
`define IRQ_MB0_DONE 0
`define IRQ_MB1_DONE 1
`define IRQ_Q0_FULL 2
`define IRQ_Q0_OVERFLOW 3
`define IRQ_Q0_OVERRUN 4
`define IRQ_Q1_FULL 5
`define IRQ_Q1_OVERFLOW 6
`define IRQ_Q1_OVERRUN 7
`define IRQ_W 8
`define CFG_OVERWRITE 0

// ==================================================
// reset values and bus answers
`define RST_WORD 32'h00000000
`define RST_IRQ 8'h00
`define FULL_STROBE 4'hF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3

`endif

/* logic/rx_queue_flags.v */
`timescale 1ns/1ps
`include "can_flags_regs.vh"

// ==================================================
// per receive queue occupancy and flag keeper
module rx_queue_flags #(
   parameter COUNT_W = 2,
   parameter [COUNT_W-1:0] DEPTH = `RXQ_DEPTH
) (
   input wire aclk,
   input wire aresetn,
   input wire frame_in,
   input wire overwrite_en,
   input wire release_set,
   input wire clr_full,
   input wire clr_overflow,
   input wire clr_overrun,
   output reg [COUNT_W-1:0] count,
   output reg full,
   output reg overflow,
   output reg overrun,
   output reg release_req,
   output reg pop,
   output reg replace,
   output wire full_evt,
   output wire overflow_evt,
   output wire overrun_evt
);
   wire [COUNT_W-1:0] one = {{(COUNT_W-1){1'b0}}, 1'b1};
   wire [COUNT_W-1:0] zero = {COUNT_W{1'b0}};
   wire at_full = (count == DEPTH);
   // a release of an empty queue just drops the request
   wire do_pop = release_req && (count != zero);
   // a pop in the same cycle makes room for the arriving frame
   wire arrive_ok = frame_in && (!at_full || do_pop);
   wire arrive_full = frame_in && at_full && !do_pop;

   assign full_evt = arrive_ok && !do_pop && (count == DEPTH - one);
   assign overflow_evt = arrive_full;
   assign overrun_evt = arrive_full && overwrite_en;

   // events win over a same-cycle software clear
   always @(posedge aclk) begin
      if (!aresetn) begin
         count <= zero;
         full <= 1'b0;
         overflow <= 1'b0;
         overrun <= 1'b0;
         release_req <= 1'b0;
         pop <= 1'b0;
         replace <= 1'b0;
      end else begin
         if (arrive_ok && !do_pop) begin
            count <= count + one;
         end else if (do_pop && !arrive_ok) begin
            count <= count - one;
         end
         if (full_evt) begin
            full <= 1'b1;
         end else if (clr_full) begin
            full <= 1'b0;
         end
         if (overflow_evt) begin
            overflow <= 1'b1;
         end else if (clr_overflow) begin
            overflow <= 1'b0;
         end
         if (overrun_evt) begin
            overrun <= 1'b1;
         end else if (clr_overrun) begin
            overrun <= 1'b0;
         end
         // request lives one cycle: the pop happens in it, then it clears
         if (release_set) begin
            release_req <= 1'b1;
         end else if (release_req) begin
            release_req <= 1'b0;
         end
         pop <= do_pop;
         replace <= arrive_full && overwrite_en;
      end
   end
endmodule // rx_queue_flags

/* logic/can_txstatus_rxfifo_flags.v */
`timescale 1ns/1ps
`include "can_flags_regs.vh"

// Function
// - done flag sets on finish or abort, clears on write-one or pending request
// - done-ok sets on clean finish, clears on error finish or write-one
// - software sets abort bit; hardware clears it when mailbox is empty
// - fault flag sets on error, clears on write-one or next start
// - arbitration-lost flag sets on loss, clears on write-one or next start
// - overrun flag sets when overwrite enabled and queue overruns
// - software sets release bit; hardware clears it after dequeuing
// - overfull flag sets on overflow, clears only on write-one
// - full flag sets when queue becomes full, clears on write-one
// - two-bit count field reports frames held in the queue
// - second queue mirrors the first in its own status word
module can_txstatus_rxfifo_flags #(
   parameter ADDR_W = 8,
   parameter MAILBOXES = 2,
   parameter COUNT_W = 2
) (
   input wire aclk,
   input wire aresetn,
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [MAILBOXES-1:0] tx_start,
   input wire [MAILBOXES-1:0] tx_end_ok,
   input wire [MAILBOXES-1:0] tx_end_err,
   input wire [MAILBOXES-1:0] tx_aborted,
   input wire [MAILBOXES-1:0] tx_arb_loss,
   input wire [MAILBOXES-1:0] tx_error,
   input wire [MAILBOXES-1:0] mbox_empty,
   output reg [MAILBOXES-1:0] tx_request,
   output reg [MAILBOXES-1:0] abort_req,
   input wire [1:0] rx_frame,
   output reg [1:0] rx_pop,
   output reg [1:0] rx_replace,
   output reg irq
);
   // ==================================================
   // address decode, shared by the read and write paths
   function [2:0] reg_sel;
      input [ADDR_W-1:0] addr;
      begin
         if (addr == `OFS_TX_MAILBOX_STATUS) begin
            reg_sel = `SEL_TXST;
         end else if (addr == `OFS_RX_QUEUE0_STATUS) begin
            reg_sel = `SEL_RXQ0;
         end else if (addr == `OFS_RX_QUEUE1_STATUS) begin
            reg_sel = `SEL_RXQ1;
         end else if (addr == `OFS_IRQ_STATUS) begin
            reg_sel = `SEL_IRQS;
         end else if (addr == `OFS_IRQ_MASK) begin
            reg_sel = `SEL_IRQM;
         end else if (addr == `OFS_RX_CONFIG) begin
            reg_sel = `SEL_CFG;
         end else if (addr == `OFS_TX_REQUEST) begin
            reg_sel = `SEL_TXREQ;
         end else begin
            reg_sel = `SEL_NONE;
         end
      end
   endfunction

   // ==================================================
   // write channel: address and data taken in either order
   reg aw_held;
   reg w_held;
   reg [ADDR_W-1:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire wr_go = aw_held && w_held && !s_axi_bvalid;
   wire [2:0] wr_sel = reg_sel(aw_addr);
   // partial-lane writes are refused so a half word never lands
   wire wr_full = (w_strb == `FULL_STROBE);
   wire wr_en = wr_go && wr_full && (wr_sel != `SEL_NONE);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= {ADDR_W{1'b0}};
         w_data <= `RST_WORD;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (wr_sel == `SEL_NONE) begin
               s_axi_bresp <= `RESP_DECERR;
            end else if (!wr_full) begin
               s_axi_bresp <= `RESP_SLVERR;
            end else begin
               s_axi_bresp <= `RESP_OKAY;
            end
         end
         // channels reopen only once the response is gone
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // write-one strobes per register
   wire [31:0] wr_txst = (wr_en && wr_sel == `SEL_TXST) ? w_data : `RST_WORD;
   wire [31:0] wr_q0 = (wr_en && wr_sel == `SEL_RXQ0) ? w_data : `RST_WORD;
   wire [31:0] wr_q1 = (wr_en && wr_sel == `SEL_RXQ1) ? w_data : `RST_WORD;
   wire [31:0] wr_irqs = (wr_en && wr_sel == `SEL_IRQS) ? w_data : `RST_WORD;
   wire [31:0] wr_txreq = (wr_en && wr_sel == `SEL_TXREQ) ? w_data : `RST_WORD;

   // ==================================================
   // mailbox flags, one copy per mailbox
   reg overwrite_en;
   wire [31:0] tx_status_word;
   wire [MAILBOXES-1:0] done_evt;

   genvar m;
   generate
      for (m = 0; m < MAILBOXES; m = m + 1) begin : g_mbox
         reg done;
         reg done_ok;
         reg arb_lost;
         reg tx_fault;
         // writing one to done also wipes the three outcome flags
         wire clr_all = wr_txst[m*`MB_STRIDE+`MB_DONE];
         assign done_evt[m] = tx_end_ok[m] || tx_end_err[m] || tx_aborted[m];

         always @(posedge aclk) begin
            if (!aresetn) begin
               done <= 1'b0;
               done_ok <= 1'b0;
               arb_lost <= 1'b0;
               tx_fault <= 1'b0;
               abort_req[m] <= 1'b0;
               tx_request[m] <= 1'b0;
            end else begin
               // reads zero while a request is pending or sending
               if (done_evt[m]) begin
                  done <= 1'b1;
               end else if (clr_all || tx_request[m]) begin
                  done <= 1'b0;
               end
               if (tx_end_ok[m]) begin
                  done_ok <= 1'b1;
               end else if (tx_end_err[m] || clr_all || wr_txst[m*`MB_STRIDE+`MB_DONE_OK]) begin
                  done_ok <= 1'b0;
               end
               if (tx_arb_loss[m]) begin
                  arb_lost <= 1'b1;
               end else if (tx_start[m] || clr_all || wr_txst[m*`MB_STRIDE+`MB_ARB_LOST]) begin
                  arb_lost <= 1'b0;
               end
               if (tx_error[m]) begin
                  tx_fault <= 1'b1;
               end else if (tx_start[m] || clr_all || wr_txst[m*`MB_STRIDE+`MB_TX_FAULT]) begin
                  tx_fault <= 1'b0;
               end
               // an empty mailbox has nothing to stop, so it drops the request
               if (mbox_empty[m]) begin
                  abort_req[m] <= 1'b0;
               end else if (wr_txst[m*`MB_STRIDE+`MB_ABORT]) begin
                  abort_req[m] <= 1'b1;
               end
               // request stands until the transmitter starts the frame
               if (wr_txreq[m]) begin
                  tx_request[m] <= 1'b1;
               end else if (tx_start[m]) begin
                  tx_request[m] <= 1'b0;
               end
            end
         end

         // reserved positions of each mailbox byte read as zero
         assign tx_status_word[m*`MB_STRIDE+`MB_DONE] = done;
         assign tx_status_word[m*`MB_STRIDE+`MB_DONE_OK] = done_ok;
         assign tx_status_word[m*`MB_STRIDE+`MB_ARB_LOST] = arb_lost;
         assign tx_status_word[m*`MB_STRIDE+`MB_TX_FAULT] = tx_fault;
         assign tx_status_word[m*`MB_STRIDE+6:m*`MB_STRIDE+4] = 3'h0;
         assign tx_status_word[m*`MB_STRIDE+`MB_ABORT] = abort_req[m];
      end
   endgenerate
   assign tx_status_word[31:MAILBOXES*`MB_STRIDE] = {(32-MAILBOXES*`MB_STRIDE){1'b0}};

   // ==================================================
   // receive queues, identical copies with their own status words
   wire [COUNT_W-1:0] q_count [0:1];
   wire [1:0] q_full;
   wire [1:0] q_overflow;
   wire [1:0] q_overrun;
   wire [1:0] q_release;
   wire [1:0] q_pop;
   wire [1:0] q_replace;
   wire [1:0] q_full_evt;
   wire [1:0] q_overflow_evt;
   wire [1:0] q_overrun_evt;
   wire [31:0] wr_q [0:1];
   wire [31:0] q_word [0:1];
   assign wr_q[0] = wr_q0;
   assign wr_q[1] = wr_q1;

   genvar q;
   generate
      for (q = 0; q < 2; q = q + 1) begin : g_rxq
         rx_queue_flags #(
            .COUNT_W(COUNT_W)
         ) u_queue (
            .aclk(aclk),
            .aresetn(aresetn),
            .frame_in(rx_frame[q]),
            .overwrite_en(overwrite_en),
            .release_set(wr_q[q][`RXQ_RELEASE]),
            .clr_full(wr_q[q][`RXQ_FULL]),
            .clr_overflow(wr_q[q][`RXQ_OVERFLOW]),
            .clr_overrun(wr_q[q][`RXQ_OVERRUN]),
            .count(q_count[q]),
            .full(q_full[q]),
            .overflow(q_overflow[q]),
            .overrun(q_overrun[q]),
            .release_req(q_release[q]),
            .pop(q_pop[q]),
            .replace(q_replace[q]),
            .full_evt(q_full_evt[q]),
            .overflow_evt(q_overflow_evt[q]),
            .overrun_evt(q_overrun_evt[q])
         );
         // same layout for both queues, reserved bits read zero
         assign q_word[q] = {23'h000000, q_overrun[q], 2'h0, q_release[q], q_overflow[q],
                             q_full[q], 1'b0, q_count[q]};
      end
   endgenerate

   // ==================================================
   // interrupt status, mask and line
   reg [`IRQ_W-1:0] irq_status;
   reg [`IRQ_W-1:0] irq_mask;
   wire [`IRQ_W-1:0] irq_evt = {q_overrun_evt[1], q_overflow_evt[1], q_full_evt[1],
                                q_overrun_evt[0], q_overflow_evt[0], q_full_evt[0],
                                done_evt[1], done_evt[0]};

   // set wins over write-one-to-clear in the same cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= `RST_IRQ;
         irq_mask <= `RST_IRQ;
         overwrite_en <= 1'b0;
         irq <= 1'b0;
         rx_pop <= 2'h0;
         rx_replace <= 2'h0;
      end else begin
         irq_status <= irq_evt | (irq_status & ~wr_irqs[`IRQ_W-1:0]);
         if (wr_en && wr_sel == `SEL_IRQM) begin
            irq_mask <= w_data[`IRQ_W-1:0];
         end
         if (wr_en && wr_sel == `SEL_CFG) begin
            overwrite_en <= w_data[`CFG_OVERWRITE];
         end
         // one cycle behind the status bit, to keep the pin on a flop
         irq <= |(irq_status & irq_mask);
         rx_pop <= q_pop;
         rx_replace <= q_replace;
      end
   end

   // ==================================================
   // read channel, answer one cycle after the address is taken
   reg [31:0] rd_word;
   wire [2:0] rd_sel = reg_sel(s_axi_araddr);

   always @* begin
      rd_word = `RST_WORD;
      case (rd_sel)
         `SEL_TXST: rd_word = tx_status_word;
         `SEL_RXQ0: rd_word = q_word[0];
         `SEL_RXQ1: rd_word = q_word[1];
         `SEL_IRQS: rd_word = {{(32-`IRQ_W){1'b0}}, irq_status};
         `SEL_IRQM: rd_word = {{(32-`IRQ_W){1'b0}}, irq_mask};
         `SEL_CFG: rd_word = {31'h00000000, overwrite_en};
         `SEL_TXREQ: rd_word = {{(32-MAILBOXES){1'b0}}, tx_request};
         default: rd_word = `RST_WORD;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `RST_WORD;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (rd_sel == `SEL_NONE) ? `RESP_DECERR : `RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule // can_txstatus_rxfifo_flags

/* tb/can_flags_sva.sv */
`timescale 1ns/1ps

// ==================================================
// port checker for the flag block
module can_flags_sva #(
   parameter MAILBOXES = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [MAILBOXES-1:0] tx_start,
   input wire logic [MAILBOXES-1:0] tx_request,
   input wire logic [MAILBOXES-1:0] abort_req,
   input wire logic [MAILBOXES-1:0] mbox_empty,
   input wire logic [1:0] rx_frame,
   input wire logic [1:0] rx_pop,
   input wire logic [1:0] rx_replace
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // hardware clear of the stop bit beats any software set
   a_abort_clear0: assert property (mbox_empty[0] |=> !abort_req[0])
      else $error("stop bit 0 held while mailbox empty");
   a_abort_clear1: assert property (mbox_empty[1] |=> !abort_req[1])
      else $error("stop bit 1 held while mailbox empty");
   a_req_cleared: assert property (tx_start[0] |=> !tx_request[0])
      else $error("send request kept after start");
   a_pop_single: assert property (rx_pop[0] |=> !rx_pop[0])
      else $error("queue release lasted two cycles");
   a_replace_cause0: assert property (rx_replace[0] |-> $past(rx_frame[0], 2))
      else $error("queue 0 replace without arriving frame");
   a_replace_cause1: assert property (rx_replace[1] |-> $past(rx_frame[1], 2))
      else $error("queue 1 replace without arriving frame");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write response late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule // can_flags_sva

bind can_txstatus_rxfifo_flags can_flags_sva #(.MAILBOXES(MAILBOXES)) can_flags_sva_i (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .tx_start, .tx_request, .abort_req, .mbox_empty, .rx_frame, .rx_pop, .rx_replace);

/* tb/can_bus_model.sv */
`timescale 1ns/1ps

// ==================================================
// far side: bus with remote nodes
module can_bus_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] tx_request,
   input wire logic [1:0] abort_req,
   output logic [1:0] tx_start = 2'h0,
   output logic [1:0] tx_end_ok = 2'h0,
   output logic [1:0] tx_end_err = 2'h0,
   output logic [1:0] tx_aborted = 2'h0,
   output logic [1:0] tx_arb_loss = 2'h0,
   output logic [1:0] tx_error = 2'h0,
   output logic [1:0] mbox_empty = 2'h3,
   output logic [1:0] rx_frame = 2'h0
);
   int lat = 2; // one less than the cycles of wait and of frame time, slow bus when large
   int outcome [2] = '{0, 0}; // 0 clean, 1 error, 2 arbitration lost
   int cnt [2] = '{0, 0};
   logic [1:0] busy = 2'h0;

   // back-to-back frames: line held n cycles gives n arrivals
   task frames(input int q, input int n);
      @(posedge aclk);
      rx_frame[q] <= 1'h1;
      repeat (n) @(posedge aclk);
      rx_frame[q] <= 1'h0;
   endtask

   // per mailbox: wait, start, then finish, fail or abort
   always @(posedge aclk) begin
      for (int n = 0; n < 2; n++) begin
         {tx_start[n], tx_end_ok[n], tx_end_err[n], tx_aborted[n], tx_arb_loss[n], tx_error[n]} <= 6'h00;
         if (!aresetn) begin
            busy[n] <= 1'h0;
            cnt[n] <= 0;
            mbox_empty[n] <= 1'h1;
         end else if (!busy[n] && tx_request[n]) begin
            mbox_empty[n] <= 1'h0;
            cnt[n] <= (cnt[n] == lat) ? 0 : cnt[n] + 1;
            busy[n] <= (cnt[n] == lat);
            tx_start[n] <= (cnt[n] == lat);
         end else if (busy[n] && abort_req[n]) begin
            tx_aborted[n] <= 1'h1; // stop honoured, mailbox empties
            busy[n] <= 1'h0;
            mbox_empty[n] <= 1'h1;
         end else if (busy[n]) begin
            cnt[n] <= (cnt[n] == lat) ? 0 : cnt[n] + 1;
            if (cnt[n] == lat) begin
               busy[n] <= 1'h0;
               mbox_empty[n] <= 1'h1;
               tx_end_ok[n] <= (outcome[n] == 0);
               tx_end_err[n] <= (outcome[n] != 0);
               tx_error[n] <= (outcome[n] == 1);
               tx_arb_loss[n] <= (outcome[n] == 2);
            end
         end
      end
   end
endmodule // can_bus_model

/* tb/tb_top.sv */
`timescale 1ns/1ps
`include "can_flags_regs.vh"

// ==================================================
// self-checking bench
module tb_top;
   localparam [7:0] TXS = `OFS_TX_MAILBOX_STATUS, Q0 = `OFS_RX_QUEUE0_STATUS, Q1 = `OFS_RX_QUEUE1_STATUS;
   localparam [7:0] IS = `OFS_IRQ_STATUS, IM = `OFS_IRQ_MASK, CFG = `OFS_RX_CONFIG, TRQ = `OFS_TX_REQUEST;
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000, d;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   wire awready, wready, bvalid, arready, rvalid, irq;
   wire [1:0] bresp, rresp, tx_start, tx_end_ok, tx_end_err, tx_aborted, tx_arb_loss, tx_error;
   wire [1:0] mbox_empty, tx_request, abort_req, rx_frame, rx_pop, rx_replace;
   wire [31:0] rdata;
   int fails = 0, n_tests = 0, pops = 0, reps = 0;
   logic [1:0] r;

   can_txstatus_rxfifo_flags can_txstatus_rxfifo_flags_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .tx_start(tx_start), .tx_end_ok(tx_end_ok), .tx_end_err(tx_end_err),
      .tx_aborted(tx_aborted), .tx_arb_loss(tx_arb_loss), .tx_error(tx_error), .mbox_empty(mbox_empty),
      .tx_request(tx_request), .abort_req(abort_req), .rx_frame(rx_frame), .rx_pop(rx_pop),
      .rx_replace(rx_replace), .irq(irq));
   can_bus_model can_bus_model_i (.aclk(aclk), .aresetn(aresetn), .tx_request(tx_request),
      .abort_req(abort_req), .tx_start(tx_start), .tx_end_ok(tx_end_ok), .tx_end_err(tx_end_err),
      .tx_aborted(tx_aborted), .tx_arb_loss(tx_arb_loss), .tx_error(tx_error), .mbox_empty(mbox_empty),
      .rx_frame(rx_frame));

   // 125 MHz clock
   initial forever #4 aclk = ~aclk;

   // count queue 0 release and queue 1 replace pulses, seen only at the ports
   always @(posedge aclk) begin
      if (rx_pop[0] === 1'h1) pops++;
      if (rx_replace[1] === 1'h1) reps++;
   end

   task test_done;
      $display("comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task chk_bit(input logic got, input logic exp);
      chk({31'h00000000, got}, {31'h00000000, exp});
   endtask

   // ==================================================
   // bus master; lane strobe given per call, reserved bits written as zero
   task wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] q);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      {awvalid, wvalid, bready} <= 3'h7;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid === 1'h1) begin
            q = bresp;
            bready <= 1'h0;
            break;
         end
      end
      if (i == 50) begin fails++; test_done(); end
   endtask

   task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] q);
      int i;
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid === 1'h1) begin
            v = rdata;
            q = rresp;
            rready <= 1'h0;
            break;
         end
      end
      if (i == 50) begin fails++; test_done(); end
   endtask

   task w(input logic [7:0] a, input logic [31:0] v);
      wr(a, v, `FULL_STROBE, r);
      chk(r, `RESP_OKAY);
   endtask

   task rdc(input logic [7:0] a, input logic [31:0] e);
      rd(a, d, r);
      chk(d, e);
      chk(r, `RESP_OKAY);
   endtask

   // polling is bounded; running out ends the run
   task poll(input logic [7:0] a, input logic [31:0] m);
      int i;
      for (i = 0; i < 100; i++) begin
         rd(a, d, r);
         if ((d & m) != 0) break;
      end
      if (i == 100) begin fails++; test_done(); end
   endtask

   // ==================================================
   // scenarios
   task t_reset;
      logic [7:0] regs [7] = '{TXS, Q0, Q1, IS, IM, CFG, TRQ};
      foreach (regs[i]) rdc(regs[i], `RST_WORD);
   endtask

   task t_refuse;
      rd(8'h04, d, r);
      chk(d, 32'h00000000);
      chk(r, `RESP_DECERR);
      wr(8'h04, 32'h00000001, `FULL_STROBE, r);
      chk(r, `RESP_DECERR);
      wr(TRQ, 32'h00000001, 4'h1, r);
      chk(r, `RESP_SLVERR);
      rdc(TRQ, 32'h00000000);
   endtask

   task t_tx_mbox0;
      w(TRQ, 32'h00000001);
      poll(TXS, 32'h00000001);
      rdc(TXS, 32'h00000003);
      can_bus_model_i.outcome[0] = 1;
      w(TRQ, 32'h00000001);
      poll(TXS, 32'h00000001);
      rdc(TXS, 32'h00000009);
      w(TXS, 32'h00000001);
      rdc(TXS, 32'h00000000);
      can_bus_model_i.outcome[0] = 0;
   endtask

   task t_tx_mbox1;
      can_bus_model_i.outcome[1] = 1;
      w(TRQ, 32'h00000002);
      poll(TXS, 32'h00000100);
      rdc(TXS, 32'h00000900);
      can_bus_model_i.outcome[1] = 2;
      can_bus_model_i.lat = 10;
      w(TRQ, 32'h00000002);
      rdc(TXS, 32'h00000800);
      poll(TXS, 32'h00000100);
      rdc(TXS, 32'h00000500);
      w(TXS, 32'h00000100);
      rdc(TXS, 32'h00000000);
   endtask

   task t_abort;
      can_bus_model_i.lat = 20;
      w(TRQ, 32'h00000001);
      rdc(TXS, 32'h00000000);
      w(TXS, 32'h00000080);
      rdc(TXS, 32'h00000080);
      poll(TXS, 32'h00000001);
      rdc(TXS, 32'h00000001);
      w(TXS, 32'h00000001);
      can_bus_model_i.lat = 2;
   endtask

   task t_rxq0;
      w(IM, 32'h00000008);
      can_bus_model_i.frames(0, 3);
      rdc(Q0, 32'h0000000B);
      chk_bit(irq, 1'h0);
      can_bus_model_i.frames(0, 1);
      rdc(Q0, 32'h0000001B);
      chk_bit(irq, 1'h1);
      rdc(IS, 32'h0000000F);
      w(IS, 32'h00000008);
      rdc(IS, 32'h00000007);
      chk_bit(irq, 1'h0);
      w(Q0, 32'h00000020);
      rdc(Q0, 32'h0000001A);
      chk(pops, 1);
      w(Q0, 32'h00000018);
      rdc(Q0, 32'h00000002);
   endtask

   task t_rxq1; // overwrite on: both queues overrun, one replace pulse counted on queue 1
      w(CFG, 32'h00000001);
      can_bus_model_i.frames(0, 2);
      rdc(Q0, 32'h0000011B);
      can_bus_model_i.frames(1, 4);
      rdc(Q1, 32'h0000011B);
      chk(reps, 1);
   endtask

   // reset for five cycles, then the scenarios in turn
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset();
      t_refuse();
      t_tx_mbox0();
      t_tx_mbox1();
      t_abort();
      t_rxq0();
      t_rxq1();
      test_done();
   end
endmodule // tb_top
